// ===== processor_special_registers.sv
`default_nettype none
// How it works
// RQ1 - Machine state saved on exception, restored on return
// RQ2 - Sixteen 32-bit segment registers
// RQ3 - All special registers 32-bit, move-to/move-from accessible
// RQ4 - Loop count decrements and tests on branch-count
// RQ5 - Link supplies target, captures return on branch-link
// RQ6 - Time base user-readable, supervisor-only writable
// RQ7 - Supervisor-only 32-bit countdown raises timer exception
// RQ8 - Timer and time base tick at quarter clock
// RQ9 - Time base halves form one 64-bit up-counter
// RQ10 - Time base counts only while enable asserted
// RQ11 - Save address captures faulting address, return resumes
// RQ12 - Save status captures state, return restores it
// RQ13 - Fault address and cause captured on data faults
// RQ14 - Version register read-only, reports model and revision
// RQ15 - Tag register holds four-bit id in low bits
// RQ16 - Instruction address match raises breakpoint
// RQ17 - Data address match raises breakpoint
// RQ18 - Two event counters steered by monitor control
// RQ19 - Sampled addresses captured on monitor interrupt
// RQ20 - Sixteen block translation registers, data and instruction
// RQ21 - Every instruction decoded as one 32-bit word
// RQ22 - External access control gates external in/out words
// RQ23 - Timer pending on zero to all-ones, keeps counting
module processor_special_registers #(
	parameter int SEG_COUNT = 16,
	parameter int BAT_COUNT = 16,
	parameter int SCRATCH_COUNT = 4,
	parameter logic [31:0] VERSION_ID = 32'h0000_0A01 // Arbitrary value
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic [31:0] gpr_data,
	output logic result_valid,
	output logic [31:0] result_data,
	output logic priv_fault,
	output logic ext_access_fault,
	output logic resume_valid,
	output logic [31:0] resume_addr,
	input wire logic exc_take,
	input wire logic [31:0] exc_addr,
	input wire logic exc_data_fault,
	input wire logic [31:0] fault_addr,
	input wire logic [31:0] fault_cause,
	input wire logic branch_count,
	output logic count_zero,
	input wire logic branch_link,
	input wire logic [31:0] link_addr,
	output logic [31:0] link_target,
	output logic [31:0] machine_state,
	input wire logic timebase_count_enable_n,
	input wire logic timer_ack,
	output logic timer_pending,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	input wire logic data_valid,
	input wire logic [31:0] data_addr,
	output logic breakpoint_hit,
	input wire logic [7:0] perf_events,
	input wire logic [31:0] sample_instr,
	input wire logic [31:0] sample_data,
	input wire logic perf_ack,
	output logic perf_pending,
	output logic [3:0] processor_tag_id
);
	////////////////////////////////////////////////////////////////////////
	// Elaboration check: decode assumes these fixed counts
	if (SEG_COUNT != 16 || BAT_COUNT != 16 || SCRATCH_COUNT != 4) begin : g_bad
		$error("unsupported register counts");
	end

	// Which numbers user mode may reach
	function automatic logic access_ok(input logic [9:0] num,
		input logic wr, input logic user);
		logic ok;
		ok = !user;
		if (num == special_regs_pkg::NUM_LINK ||
			num == special_regs_pkg::NUM_LOOP ||
			num == special_regs_pkg::NUM_INT_EXC)
			ok = 1'b1;
		if ((num == special_regs_pkg::NUM_TB_LOWER ||
			num == special_regs_pkg::NUM_TB_UPPER) && !wr)
			ok = 1'b1; // RQ6
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] state_ff, link_ff, loop_ff, int_exc_ff, cause_ff, faddr_ff;
	logic [31:0] down_ff, page_table_ff, save_addr_ff, save_status_ff;
	logic [31:0] ext_access_ff, impl_ctl_ff, ibrk_ff, dbrk_ff, perf_ctl_ff;
	logic [31:0] perf_cnt1_ff, perf_cnt2_ff, samp_instr_ff, samp_data_ff;
	logic [63:0] time_base_ff;
	logic [3:0] tag_ff;
	logic [31:0] seg_ff [SEG_COUNT];
	logic [31:0] bat_ff [BAT_COUNT];
	logic [31:0] scratch_ff [SCRATCH_COUNT];
	logic [1:0] prescale_ff;
	logic timer_pending_ff, perf_pending_ff, count_zero_ff, brk_ff;
	logic result_valid_ff, priv_fault_ff, ext_fault_ff, resume_valid_ff;
	logic [31:0] result_ff;

	////////////////////////////////////////////////////////////////////////
	// Decode of the single instruction word
	logic [5:0] prim;
	logic [9:0] ext, num;
	logic [3:0] seg_idx;
	logic user, sys, is_mt, is_mf, is_mts, is_mfs, is_mtg, is_mfg, is_ret;
	logic is_ext_io, mt_ok, mf_ok, sup_ok, tick;
	assign prim = instr_word[special_regs_pkg::PRIM_HI:
		special_regs_pkg::PRIM_LO]; // RQ21
	assign ext = instr_word[special_regs_pkg::EXT_HI:
		special_regs_pkg::EXT_LO];
	assign num = {instr_word[15:11], instr_word[20:16]}; // RQ21
	assign seg_idx = instr_word[special_regs_pkg::SEG_IDX_HI:
		special_regs_pkg::SEG_IDX_LO];
	assign user = state_ff[special_regs_pkg::STATE_USER_BIT];
	assign sys = instr_valid && prim == special_regs_pkg::OP_SYSTEM;
	assign is_mt = sys && ext == special_regs_pkg::EXT_MT_SPECIAL;
	assign is_mf = sys && ext == special_regs_pkg::EXT_MF_SPECIAL;
	assign is_mts = sys && ext == special_regs_pkg::EXT_MT_STATE;
	assign is_mfs = sys && ext == special_regs_pkg::EXT_MF_STATE;
	assign is_mtg = sys && ext == special_regs_pkg::EXT_MT_SEGMENT;
	assign is_mfg = sys && ext == special_regs_pkg::EXT_MF_SEGMENT;
	assign is_ret = sys && ext == special_regs_pkg::EXT_RETURN && !user;
	assign is_ext_io = sys && (ext == special_regs_pkg::EXT_EXT_IN ||
		ext == special_regs_pkg::EXT_EXT_OUT);
	assign mt_ok = is_mt && access_ok(num, 1'b1, user); // RQ3
	assign mf_ok = is_mf && access_ok(num, 1'b0, user); // RQ3
	assign sup_ok = !user;
	assign tick = prescale_ff == special_regs_pkg::TICK_LAST;

	////////////////////////////////////////////////////////////////////////
	// Read value of a special register number
	logic [31:0] rd_value;
	always_comb begin
		rd_value = special_regs_pkg::RESET_WORD;
		case (num)
			special_regs_pkg::NUM_INT_EXC: rd_value = int_exc_ff;
			special_regs_pkg::NUM_LINK: rd_value = link_ff;
			special_regs_pkg::NUM_LOOP: rd_value = loop_ff;
			special_regs_pkg::NUM_FAULT_CAUSE: rd_value = cause_ff;
			special_regs_pkg::NUM_FAULT_ADDR: rd_value = faddr_ff;
			special_regs_pkg::NUM_COUNTDOWN: rd_value = down_ff;
			special_regs_pkg::NUM_PAGE_TABLE: rd_value = page_table_ff;
			special_regs_pkg::NUM_SAVE_ADDR: rd_value = save_addr_ff;
			special_regs_pkg::NUM_SAVE_STATUS: rd_value = save_status_ff;
			special_regs_pkg::NUM_EXT_ACCESS: rd_value = ext_access_ff;
			special_regs_pkg::NUM_TB_LOWER: rd_value = time_base_ff[31:0];
			special_regs_pkg::NUM_TB_UPPER: rd_value = time_base_ff[63:32];
			special_regs_pkg::NUM_VERSION: rd_value = VERSION_ID; // RQ14
			special_regs_pkg::NUM_PERF_CTL: rd_value = perf_ctl_ff;
			special_regs_pkg::NUM_PERF_CNT1: rd_value = perf_cnt1_ff;
			special_regs_pkg::NUM_PERF_CNT2: rd_value = perf_cnt2_ff;
			special_regs_pkg::NUM_SAMPLED_INSTR: rd_value = samp_instr_ff;
			special_regs_pkg::NUM_SAMPLED_DATA: rd_value = samp_data_ff;
			special_regs_pkg::NUM_IMPL_CTL0: rd_value = impl_ctl_ff;
			special_regs_pkg::NUM_INSTR_BRK: rd_value = ibrk_ff;
			special_regs_pkg::NUM_DATA_BRK: rd_value = dbrk_ff;
			special_regs_pkg::NUM_TAG: rd_value = {28'h0000000, tag_ff};
			default: begin
				if (num[9:4] == special_regs_pkg::NUM_BAT_BASE[9:4])
					rd_value = bat_ff[num[3:0]]; // RQ20
				else if (num[9:2] == special_regs_pkg::NUM_SCRATCH_BASE[9:2])
					rd_value = scratch_ff[num[1:0]];
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Read results, privilege and external access faults
	always_ff @(posedge mclk) begin
		if (rst) begin
			result_valid_ff <= 1'b0;
			result_ff <= special_regs_pkg::RESET_WORD;
			priv_fault_ff <= 1'b0;
			ext_fault_ff <= 1'b0;
		end else begin
			result_valid_ff <= mf_ok || (is_mfs && sup_ok) ||
				(is_mfg && sup_ok);
			if (mf_ok)
				result_ff <= rd_value; // RQ3
			else if (is_mfs && sup_ok)
				result_ff <= state_ff;
			else if (is_mfg && sup_ok)
				result_ff <= seg_ff[seg_idx]; // RQ2
			priv_fault_ff <= (is_mt && !mt_ok) || (is_mf && !mf_ok) ||
				(user && (is_mts || is_mfs || is_mtg || is_mfg)) ||
				(user && sys && ext == special_regs_pkg::EXT_RETURN);
			ext_fault_ff <= is_ext_io &&
				!ext_access_ff[special_regs_pkg::EXT_ACCESS_EN_BIT]; // RQ22
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Machine state, save/restore pair and return
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_ff <= special_regs_pkg::RESET_WORD;
			save_addr_ff <= special_regs_pkg::RESET_WORD;
			save_status_ff <= special_regs_pkg::RESET_WORD;
			resume_valid_ff <= 1'b0;
		end else begin
			resume_valid_ff <= is_ret && !exc_take; // RQ11
			if (exc_take) begin
				save_addr_ff <= exc_addr; // RQ11
				save_status_ff <= state_ff; // RQ1 RQ12
				state_ff[special_regs_pkg::STATE_USER_BIT] <= 1'b0;
			end else begin
				if (is_ret)
					state_ff <= save_status_ff; // RQ1 RQ12
				else if (is_mts && sup_ok)
					state_ff <= gpr_data;
				if (mt_ok && num == special_regs_pkg::NUM_SAVE_ADDR)
					save_addr_ff <= gpr_data;
				if (mt_ok && num == special_regs_pkg::NUM_SAVE_STATUS)
					save_status_ff <= gpr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault capture
	always_ff @(posedge mclk) begin
		if (rst) begin
			faddr_ff <= special_regs_pkg::RESET_WORD;
			cause_ff <= special_regs_pkg::RESET_WORD;
		end else if (exc_take && exc_data_fault) begin
			faddr_ff <= fault_addr; // RQ13
			cause_ff <= fault_cause; // RQ13
		end else begin
			if (mt_ok && num == special_regs_pkg::NUM_FAULT_ADDR)
				faddr_ff <= gpr_data;
			if (mt_ok && num == special_regs_pkg::NUM_FAULT_CAUSE)
				cause_ff <= gpr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link and loop count, hardware update wins over move-to
	always_ff @(posedge mclk) begin
		if (rst) begin
			link_ff <= special_regs_pkg::RESET_WORD;
			loop_ff <= special_regs_pkg::RESET_WORD;
			count_zero_ff <= 1'b0;
		end else begin
			if (branch_link)
				link_ff <= link_addr; // RQ5
			else if (mt_ok && num == special_regs_pkg::NUM_LINK)
				link_ff <= gpr_data;
			if (branch_count) begin
				loop_ff <= loop_ff - 32'h0000_0001; // RQ4
				count_zero_ff <= loop_ff == 32'h0000_0001; // RQ4
			end else if (mt_ok && num == special_regs_pkg::NUM_LOOP) begin
				loop_ff <= gpr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain storage: arrays, control and identity registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < SEG_COUNT; i++)
				seg_ff[i] <= special_regs_pkg::RESET_WORD;
			for (int i = 0; i < BAT_COUNT; i++)
				bat_ff[i] <= special_regs_pkg::RESET_WORD;
			for (int i = 0; i < SCRATCH_COUNT; i++)
				scratch_ff[i] <= special_regs_pkg::RESET_WORD;
			int_exc_ff <= special_regs_pkg::RESET_WORD;
			page_table_ff <= special_regs_pkg::RESET_WORD;
			ext_access_ff <= special_regs_pkg::RESET_WORD;
			impl_ctl_ff <= special_regs_pkg::RESET_WORD;
			ibrk_ff <= special_regs_pkg::RESET_WORD;
			dbrk_ff <= special_regs_pkg::RESET_WORD;
			perf_ctl_ff <= special_regs_pkg::RESET_WORD;
			tag_ff <= special_regs_pkg::RESET_WORD[3:0];
		end else begin
			if (is_mtg && sup_ok)
				seg_ff[seg_idx] <= gpr_data; // RQ2
			if (mt_ok && num[9:4] == special_regs_pkg::NUM_BAT_BASE[9:4])
				bat_ff[num[3:0]] <= gpr_data; // RQ20
			if (mt_ok && num[9:2] == special_regs_pkg::NUM_SCRATCH_BASE[9:2])
				scratch_ff[num[1:0]] <= gpr_data;
			if (mt_ok) begin
				case (num)
					special_regs_pkg::NUM_INT_EXC: int_exc_ff <= gpr_data;
					special_regs_pkg::NUM_PAGE_TABLE: page_table_ff <= gpr_data;
					special_regs_pkg::NUM_EXT_ACCESS: ext_access_ff <= gpr_data;
					special_regs_pkg::NUM_IMPL_CTL0: impl_ctl_ff <= gpr_data;
					special_regs_pkg::NUM_INSTR_BRK: ibrk_ff <= gpr_data;
					special_regs_pkg::NUM_DATA_BRK: dbrk_ff <= gpr_data;
					special_regs_pkg::NUM_PERF_CTL: perf_ctl_ff <= gpr_data;
					special_regs_pkg::NUM_TAG: tag_ff <= gpr_data[3:0]; // RQ15
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Quarter-rate tick, time base and countdown timer
	always_ff @(posedge mclk) begin
		if (rst)
			prescale_ff <= 2'h0;
		else
			prescale_ff <= prescale_ff + 2'h1; // RQ8
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			time_base_ff <= special_regs_pkg::RESET_TB;
		end else if (mt_ok && num == special_regs_pkg::NUM_TB_LOWER) begin
			time_base_ff[31:0] <= gpr_data; // RQ6
		end else if (mt_ok && num == special_regs_pkg::NUM_TB_UPPER) begin
			time_base_ff[63:32] <= gpr_data; // RQ6
		end else if (tick && !timebase_count_enable_n) begin
			time_base_ff <= time_base_ff + 64'h1; // RQ8 RQ9 RQ10
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			down_ff <= special_regs_pkg::RESET_WORD;
			timer_pending_ff <= 1'b0;
		end else begin
			if (mt_ok && num == special_regs_pkg::NUM_COUNTDOWN)
				down_ff <= gpr_data; // RQ7
			else if (tick)
				down_ff <= down_ff - 32'h0000_0001; // RQ7 RQ8 RQ23
			// Set wins over acknowledge
			if (tick && down_ff == special_regs_pkg::RESET_WORD &&
				!(mt_ok && num == special_regs_pkg::NUM_COUNTDOWN))
				timer_pending_ff <= 1'b1; // RQ7 RQ23
			else if (timer_ack)
				timer_pending_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Breakpoint compare on word addresses
	always_ff @(posedge mclk) begin
		if (rst)
			brk_ff <= 1'b0;
		else
			brk_ff <= (fetch_valid && ibrk_ff[special_regs_pkg::BRK_EN_BIT] &&
				fetch_addr[31:2] == ibrk_ff[31:2]) || // RQ16
				(data_valid && dbrk_ff[special_regs_pkg::BRK_EN_BIT] &&
				data_addr[31:2] == dbrk_ff[31:2]); // RQ17
	end

	////////////////////////////////////////////////////////////////////////
	// Performance counters, interrupt and sampled addresses
	logic ev1, ev2, perf_raise;
	assign ev1 = perf_ctl_ff[special_regs_pkg::PERF_EN1_BIT] &&
		perf_events[perf_ctl_ff[special_regs_pkg::PERF_SEL1_LO +:
		special_regs_pkg::PERF_SEL_WIDTH]]; // RQ18
	assign ev2 = perf_ctl_ff[special_regs_pkg::PERF_EN2_BIT] &&
		perf_events[perf_ctl_ff[special_regs_pkg::PERF_SEL2_LO +:
		special_regs_pkg::PERF_SEL_WIDTH]]; // RQ18
	assign perf_raise = perf_ctl_ff[special_regs_pkg::PERF_INT_EN_BIT] &&
		(perf_cnt1_ff[31] || perf_cnt2_ff[31]) && !perf_pending_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			perf_cnt1_ff <= special_regs_pkg::RESET_WORD;
			perf_cnt2_ff <= special_regs_pkg::RESET_WORD;
			samp_instr_ff <= special_regs_pkg::RESET_WORD;
			samp_data_ff <= special_regs_pkg::RESET_WORD;
			perf_pending_ff <= 1'b0;
		end else begin
			if (mt_ok && num == special_regs_pkg::NUM_PERF_CNT1)
				perf_cnt1_ff <= gpr_data;
			else if (ev1)
				perf_cnt1_ff <= perf_cnt1_ff + 32'h0000_0001; // RQ18
			if (mt_ok && num == special_regs_pkg::NUM_PERF_CNT2)
				perf_cnt2_ff <= gpr_data;
			else if (ev2)
				perf_cnt2_ff <= perf_cnt2_ff + 32'h0000_0001; // RQ18
			if (perf_raise) begin
				perf_pending_ff <= 1'b1; // RQ18
				samp_instr_ff <= sample_instr; // RQ19
				samp_data_ff <= sample_data; // RQ19
			end else if (perf_ack) begin
				perf_pending_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign result_valid = result_valid_ff;
	assign result_data = result_ff;
	assign priv_fault = priv_fault_ff;
	assign ext_access_fault = ext_fault_ff;
	assign resume_valid = resume_valid_ff;
	assign resume_addr = save_addr_ff; // RQ11
	assign count_zero = count_zero_ff;
	assign link_target = link_ff; // RQ5
	assign machine_state = state_ff;
	assign timer_pending = timer_pending_ff;
	assign breakpoint_hit = brk_ff;
	assign perf_pending = perf_pending_ff;
	assign processor_tag_id = tag_ff; // RQ15

	////////////////////////////////////////////////////////////////////////
	// Assertions
	logic tb_wr, down_wr;
	assign tb_wr = mt_ok && (num == special_regs_pkg::NUM_TB_LOWER ||
		num == special_regs_pkg::NUM_TB_UPPER);
	assign down_wr = mt_ok && num == special_regs_pkg::NUM_COUNTDOWN;

	tick_rate_a: assert property (@(posedge mclk) disable iff (rst) // RQ8
		tick |=> !tick [*3] ##1 tick)
		else $error("tick not every fourth clock");
	tb_count_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
		tick && !timebase_count_enable_n && !tb_wr
		|=> time_base_ff == $past(time_base_ff) + 64'h1)
		else $error("time base did not advance");
	tb_hold_a: assert property (@(posedge mclk) disable iff (rst) // RQ10
		(timebase_count_enable_n || !tick) && !tb_wr |=> $stable(time_base_ff))
		else $error("time base moved while stopped");
	tb_user_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
		is_mt && user && (num == special_regs_pkg::NUM_TB_LOWER ||
		num == special_regs_pkg::NUM_TB_UPPER)
		|-> !tb_wr ##1 priv_fault)
		else $error("user time base write accepted");
	down_wrap_a: assert property (@(posedge mclk) disable iff (rst) // RQ23
		tick && !down_wr && down_ff == 32'h0000_0000
		|=> down_ff == 32'hFFFF_FFFF && timer_pending ##4
		down_ff == 32'hFFFF_FFFE)
		else $error("countdown wrap mishandled");
	down_user_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
		is_mt && user && num == special_regs_pkg::NUM_COUNTDOWN
		|=> priv_fault)
		else $error("user countdown write not refused");
	exc_save_a: assert property (@(posedge mclk) disable iff (rst) // RQ12
		exc_take |=> save_addr_ff == $past(exc_addr) &&
		save_status_ff == $past(state_ff) && !user)
		else $error("exception save failed");
	return_a: assert property (@(posedge mclk) disable iff (rst) // RQ11
		is_ret && !exc_take |=> resume_valid &&
		state_ff == $past(save_status_ff) &&
		resume_addr == $past(save_addr_ff))
		else $error("return did not restore");
	loop_a: assert property (@(posedge mclk) disable iff (rst) // RQ4
		branch_count |=> loop_ff == $past(loop_ff) - 32'h0000_0001 &&
		count_zero == (loop_ff == 32'h0000_0000))
		else $error("loop count not decremented");
	link_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
		branch_link |=> link_target == $past(link_addr))
		else $error("link not captured");
	ibrk_a: assert property (@(posedge mclk) disable iff (rst) // RQ16
		fetch_valid && ibrk_ff[0] && fetch_addr[31:2] == ibrk_ff[31:2]
		|=> breakpoint_hit)
		else $error("instruction breakpoint missed");
	version_a: assert property (@(posedge mclk) disable iff (rst) // RQ14
		mf_ok && num == special_regs_pkg::NUM_VERSION
		|=> result_valid && result_data == VERSION_ID)
		else $error("version read wrong");

	tb_carry_c: cover property (@(posedge mclk) disable iff (rst)
		time_base_ff[31:0] == 32'hFFFF_FFFF ##1 time_base_ff[31:0] == 32'h0);
	timer_fire_c: cover property (@(posedge mclk) disable iff (rst)
		$rose(timer_pending));
	exc_return_c: cover property (@(posedge mclk) disable iff (rst)
		exc_take ##[1:20] is_ret);
	perf_int_c: cover property (@(posedge mclk) disable iff (rst)
		$rose(perf_pending));
endmodule
`default_nettype wire

// ===== special_regs_pkg.sv
`default_nettype none
package special_regs_pkg;
	// Instruction word fields
	localparam int PRIM_HI = 31;
	localparam int PRIM_LO = 26;
	localparam int EXT_HI = 10;
	localparam int EXT_LO = 1;
	localparam int SEG_IDX_HI = 19;
	localparam int SEG_IDX_LO = 16;
	localparam logic [5:0] OP_SYSTEM = 6'h1F;
	localparam logic [9:0] EXT_MT_SPECIAL = 10'h1D3;
	localparam logic [9:0] EXT_MF_SPECIAL = 10'h153;
	localparam logic [9:0] EXT_MT_STATE = 10'h092;
	localparam logic [9:0] EXT_MF_STATE = 10'h053;
	localparam logic [9:0] EXT_MT_SEGMENT = 10'h0D2;
	localparam logic [9:0] EXT_MF_SEGMENT = 10'h253;
	localparam logic [9:0] EXT_RETURN = 10'h032;
	localparam logic [9:0] EXT_EXT_IN = 10'h136;
	localparam logic [9:0] EXT_EXT_OUT = 10'h1B6;
	// Special register numbers
	localparam logic [9:0] NUM_INT_EXC = 10'h001;
	localparam logic [9:0] NUM_LINK = 10'h008;
	localparam logic [9:0] NUM_LOOP = 10'h009;
	localparam logic [9:0] NUM_FAULT_CAUSE = 10'h012;
	localparam logic [9:0] NUM_FAULT_ADDR = 10'h013;
	localparam logic [9:0] NUM_COUNTDOWN = 10'h016;
	localparam logic [9:0] NUM_PAGE_TABLE = 10'h019;
	localparam logic [9:0] NUM_SAVE_ADDR = 10'h01A;
	localparam logic [9:0] NUM_SAVE_STATUS = 10'h01B;
	localparam logic [9:0] NUM_SCRATCH_BASE = 10'h110;
	localparam logic [9:0] NUM_EXT_ACCESS = 10'h11A;
	localparam logic [9:0] NUM_TB_LOWER = 10'h11C;
	localparam logic [9:0] NUM_TB_UPPER = 10'h11D;
	localparam logic [9:0] NUM_VERSION = 10'h11F;
	localparam logic [9:0] NUM_BAT_BASE = 10'h210;
	localparam logic [9:0] NUM_PERF_CTL = 10'h3B8;
	localparam logic [9:0] NUM_PERF_CNT1 = 10'h3B9;
	localparam logic [9:0] NUM_PERF_CNT2 = 10'h3BA;
	localparam logic [9:0] NUM_SAMPLED_INSTR = 10'h3BB;
	localparam logic [9:0] NUM_SAMPLED_DATA = 10'h3BD;
	localparam logic [9:0] NUM_IMPL_CTL0 = 10'h3F0;
	localparam logic [9:0] NUM_INSTR_BRK = 10'h3F2;
	localparam logic [9:0] NUM_DATA_BRK = 10'h3F5;
	localparam logic [9:0] NUM_TAG = 10'h3FF;
	// Field positions
	localparam int STATE_USER_BIT = 14;
	localparam int EXT_ACCESS_EN_BIT = 31;
	localparam int BRK_EN_BIT = 0;
	localparam int BRK_ADDR_LO = 2;
	localparam int TAG_WIDTH = 4;
	localparam int PERF_EN1_BIT = 0;
	localparam int PERF_EN2_BIT = 1;
	localparam int PERF_SEL1_LO = 2;
	localparam int PERF_SEL2_LO = 5;
	localparam int PERF_SEL_WIDTH = 3;
	localparam int PERF_INT_EN_BIT = 8;
	// Reset values and timing
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [63:0] RESET_TB = 64'h0000_0000_0000_0000;
	localparam int TICK_DIVIDE = 4;
	localparam logic [1:0] TICK_LAST = 2'(TICK_DIVIDE - 1);
endpackage
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst, iv, exc, dflt, bcnt, blnk, ten_n, tack, fv, dv, pack, f;
	logic [31:0] iw, gd, adr, rd;
	logic [7:0] ev;
	logic rv, pf, ef, resv, cz, tp, bh, pp;
	logic [31:0] rdat, raddr, ltgt, mst;
	logic [3:0] tag;
	int num_errors, compares, n;
	logic [9:0] nums [6] = '{special_regs_pkg::NUM_LINK,
		special_regs_pkg::NUM_LOOP, special_regs_pkg::NUM_INT_EXC,
		special_regs_pkg::NUM_PAGE_TABLE, special_regs_pkg::NUM_SCRATCH_BASE,
		special_regs_pkg::NUM_BAT_BASE};
	processor_special_registers #(.VERSION_ID(32'h0000_5A5A))
	i_processor_special_registers (.mclk(mclk), .rst(rst),
		.instr_valid(iv), .instr_word(iw), .gpr_data(gd), .result_valid(rv),
		.result_data(rdat), .priv_fault(pf), .ext_access_fault(ef),
		.resume_valid(resv), .resume_addr(raddr), .exc_take(exc),
		.exc_addr(adr), .exc_data_fault(dflt), .fault_addr(adr),
		.fault_cause(gd), .branch_count(bcnt), .count_zero(cz),
		.branch_link(blnk), .link_addr(adr), .link_target(ltgt),
		.machine_state(mst), .timebase_count_enable_n(ten_n),
		.timer_ack(tack), .timer_pending(tp), .fetch_valid(fv),
		.fetch_addr(adr), .data_valid(dv), .data_addr(adr),
		.breakpoint_hit(bh), .perf_events(ev), .sample_instr(adr),
		.sample_data(adr), .perf_ack(pack), .perf_pending(pp),
		.processor_tag_id(tag));
	// Free-running bus clock
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////
	task step;
		@(posedge mclk);
		#1;
	endtask
	task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task tally_and_finish;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// One instruction, answer taken one cycle later
	task op(input logic [9:0] ext, input logic [9:0] num, input logic [31:0] d);
		step();
		iv = 1;
		gd = d;
		iw = {special_regs_pkg::OP_SYSTEM, 5'h00, num[4:0], num[9:5], ext, 1'b0};
		step();
		iv = 0;
		rd = rdat;
		f = pf;
	endtask
	task wr(input logic [9:0] num, input logic [31:0] d);
		op(special_regs_pkg::EXT_MT_SPECIAL, num, d);
	endtask
	task rdr(input logic [9:0] num);
		op(special_regs_pkg::EXT_MF_SPECIAL, num, 32'h0000_0000);
	endtask
	// Bounded wait on timer or monitor pending
	task wt(input bit which);
		n = 0;
		while ((which ? pp : tp) !== 1'b1 && n < 40) begin
			step();
			n++;
		end
		if ((which ? pp : tp) !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task brk(input logic [9:0] num, input logic [31:0] a, input bit data);
		wr(num, a | 32'h0000_0001);
		adr = a + 32'h0000_0002;
		fv = !data;
		dv = data;
		step();
		{fv, dv} = 2'b00;
		f = bh;
		step();
		chk("break", f | bh, 1);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{iv, exc, dflt, bcnt, blnk, tack, fv, dv, pack} = 0;
		{iw, gd, adr, ev, num_errors, compares} = 0;
		ten_n = 1;
		rst = 1;
		repeat (8) step();
		rst = 0;
		foreach (nums[i]) begin
			wr(nums[i], 32'hA5C3_0F00 + i);
			rdr(nums[i]);
			chk("rw", rd, 32'hA5C3_0F00 + i);
		end
		op(special_regs_pkg::EXT_MT_SEGMENT, 10'h00F, 32'h1234_5678);
		op(special_regs_pkg::EXT_MF_SEGMENT, 10'h00F, 32'h0000_0000);
		chk("segment", rd, 32'h1234_5678);
		wr(special_regs_pkg::NUM_VERSION, 32'h0000_0000);
		rdr(special_regs_pkg::NUM_VERSION);
		chk("version", rd, 32'h0000_5A5A);
		chk("read valid", rv, 1);
		wr(special_regs_pkg::NUM_TAG, 32'hFFFF_FFFB);
		chk("tag", tag, 4'hB);
		wr(special_regs_pkg::NUM_TB_LOWER, 32'hFFFF_FFFF);
		wr(special_regs_pkg::NUM_TB_UPPER, 32'h0000_0000);
		repeat (8) step();
		rdr(special_regs_pkg::NUM_TB_LOWER);
		chk("tb hold", rd, 32'hFFFF_FFFF);
		ten_n = 0;
		repeat (6) step();
		ten_n = 1;
		rdr(special_regs_pkg::NUM_TB_UPPER);
		chk("tb carry", rd, 32'h0000_0001);
		// Clear the pending flag left by the wrap of the reset value
		tack = 1;
		step();
		tack = 0;
		chk("timer clear", tp, 0);
		wr(special_regs_pkg::NUM_COUNTDOWN, 32'h0000_0002);
		wt(0);
		chk("timer delay", n > 7 && n < 13, 1);
		rdr(special_regs_pkg::NUM_COUNTDOWN);
		chk("timer wrap", rd[31:4], 28'hFFF_FFFF);
		tack = 1;
		step();
		tack = 0;
		chk("timer ack", tp, 0);
		wr(special_regs_pkg::NUM_LOOP, 32'h0000_0001);
		bcnt = 1;
		step();
		bcnt = 0;
		chk("count zero", cz, 1);
		adr = 32'h0000_4440;
		blnk = 1;
		step();
		blnk = 0;
		chk("link", ltgt, 32'h0000_4440);
		brk(special_regs_pkg::NUM_INSTR_BRK, 32'h0000_2000, 0);
		brk(special_regs_pkg::NUM_DATA_BRK, 32'h0000_3000, 1);
		wr(special_regs_pkg::NUM_PERF_CNT1, 32'h7FFF_FFFF);
		wr(special_regs_pkg::NUM_PERF_CTL, 32'h0000_0101);
		ev = 8'h01;
		step();
		ev = 8'h00;
		wt(1);
		rdr(special_regs_pkg::NUM_SAMPLED_INSTR);
		chk("sampled", rd, adr);
		pack = 1;
		step();
		pack = 0;
		chk("perf ack", pp, 0);
		op(special_regs_pkg::EXT_EXT_IN, 10'h000, 32'h0000_0000);
		chk("ext off", ef, 1);
		wr(special_regs_pkg::NUM_EXT_ACCESS, 32'h8000_0000);
		op(special_regs_pkg::EXT_EXT_IN, 10'h000, 32'h0000_0000);
		chk("ext on", ef, 0);
		op(special_regs_pkg::EXT_MT_STATE, 10'h000, 32'h0000_4000);
		wr(special_regs_pkg::NUM_TB_LOWER, 32'h0000_0000);
		chk("tb user write", f, 1);
		rdr(special_regs_pkg::NUM_TB_LOWER);
		chk("tb user read", f, 0);
		rdr(special_regs_pkg::NUM_COUNTDOWN);
		chk("timer user", f, 1);
		adr = 32'h0000_1230;
		gd = 32'h0000_0044;
		{exc, dflt} = 2'b11;
		step();
		{exc, dflt} = 2'b00;
		chk("exc state", mst[14], 0);
		rdr(special_regs_pkg::NUM_SAVE_STATUS);
		chk("save status", rd, 32'h0000_4000);
		rdr(special_regs_pkg::NUM_FAULT_ADDR);
		chk("fault addr", rd, 32'h0000_1230);
		rdr(special_regs_pkg::NUM_FAULT_CAUSE);
		chk("fault cause", rd, 32'h0000_0044);
		op(special_regs_pkg::EXT_RETURN, 10'h000, 32'h0000_0000);
		chk("resume", {resv, raddr}, {1'b1, 32'h0000_1230});
		chk("restored", mst[14], 1);
		// Mid-run reset clears state, tag and both pending flags
		rst = 1;
		step();
		rst = 0;
		chk("reset", {mst, tag, tp, pp}, 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
